/* bench/bgl_display_monitor.sv */
// bgl_display_monitor: port-level assertions for the bargraph display.
// assumes it is bound into bgl_display and sees only its ports.
`timescale 1ns/10ps
module bgl_display_monitor
	import bgl_pkg::*;
#(
	parameter int NSEG = 32
)(
	// clock and reset
	input wire logic            mclk,
	input wire logic            nrst,
	// register port
	input wire logic [7:0]      reg_addr,
	input wire logic [31:0]     reg_wdata,
	input wire logic            reg_wr,
	input wire logic            reg_rd,
	input wire logic [31:0]     reg_rdata,
	// display outputs
	input wire logic [NSEG-1:0] seg_on,
	input wire logic [31:0]     digit_chars,
	input wire logic [1:0]      decimal_place_count,
	input wire logic            over_range,
	input wire logic            under_range
);
	// ----------------------------------------------------------------
	// helper state: edges since last write, flash switched off
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [3:0] quiet;
		logic       steady;
	} bgl_mon_s;
	bgl_mon_s st_q, st_d;

	// quiet saturates so the hold checks stay armed in long idle spans
	always_comb
	begin
		st_d = st_q;
		if (st_q.quiet != 4'hf)
			st_d.quiet = st_q.quiet + 4'h1;
		if (reg_wr)
			st_d.quiet = 4'h0;
		if (reg_wr && reg_addr == BGL_OFS_CMD && reg_wdata[1])
			st_d.steady = 1'b1;
		else if (reg_wr && reg_addr == BGL_OFS_CMD && reg_wdata[0])
			st_d.steady = 1'b0;
	end

	// flash starts off after reset
	always_ff @(posedge mclk or negedge nrst)
		if (!nrst)
			st_q <= '{quiet: 4'h0, steady: 1'b1};
		else
			st_q <= st_d;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);

	sequence wr_at(logic [7:0] a);
		reg_wr && reg_addr == a;
	endsequence
	sequence rd_at(logic [7:0] a);
		reg_rd && reg_addr == a;
	endsequence

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data not zero outside a read");
	ctrl_upper_a: assert property (rd_at(BGL_OFS_CTRL) |=>
		reg_rdata[31:7] == 25'h0) else $error("control upper bits set");
	over_word_a: assert property ((wr_at(BGL_OFS_READING) ##0
		$signed(reg_wdata[15:0]) > BGL_DIG_MAX) |-> ##2 over_range)
		else $error("over range flag missing");
	under_word_a: assert property ((wr_at(BGL_OFS_READING) ##0
		$signed(reg_wdata[15:0]) < BGL_DIG_MIN) |-> ##2 under_range)
		else $error("under range flag missing");
	in_range_a: assert property ((wr_at(BGL_OFS_READING) ##0
		$signed(reg_wdata[15:0]) >= BGL_DIG_MIN &&
		$signed(reg_wdata[15:0]) <= BGL_DIG_MAX) |->
		##2 (!over_range && !under_range)) else $error("range flag stuck");
	range_excl_a: assert property (!(over_range && under_range))
		else $error("over and under range together");
	dp_follow_a: assert property (wr_at(BGL_OFS_DECIMAL) |=>
		decimal_place_count == $past(reg_wdata[1:0]))
		else $error("decimal count not taken");
	text_show_a: assert property (wr_at(BGL_OFS_TEXT) |->
		##2 digit_chars == $past(reg_wdata, 2))
		else $error("host text not shown");
	steady_bar_a: assert property (st_q.steady && st_q.quiet >= 4'h4
		|-> $stable(seg_on)) else $error("bar moves while flash is off");
	digit_hold_a: assert property (st_q.quiet >= 4'h4 |->
		$stable(digit_chars) && $stable(decimal_place_count))
		else $error("digits change without a write");

endmodule : bgl_display_monitor

bind bgl_display bgl_display_monitor #(.NSEG(NSEG)) i_mon (
	.mclk                (mclk),
	.nrst                (nrst),
	.reg_addr            (reg_addr),
	.reg_wdata           (reg_wdata),
	.reg_wr              (reg_wr),
	.reg_rd              (reg_rd),
	.reg_rdata           (reg_rdata),
	.seg_on              (seg_on),
	.digit_chars         (digit_chars),
	.decimal_place_count (decimal_place_count),
	.over_range          (over_range),
	.under_range         (under_range)
);

/* bench/bgl_panel_model.sv */
// bgl_panel_model: stands in for the LED bar and digit panel.
// assumes segment bit 0 is the bottom LED; reports how many are lit.
`timescale 1ns/10ps
module bgl_panel_model #(
	parameter int NSEG = 32
)(
	// panel drive
	input  wire logic [NSEG-1:0] seg_on,
	input  wire logic [31:0]     digit_chars,
	// observation
	output logic      [8:0]      lit_count
);
	// the panel only glows; digit text is taken in but not modelled
	always_comb
	begin
		lit_count = 9'h0;
		for (int i = 0; i < NSEG; i++)
			lit_count = lit_count + {8'h0, seg_on[i]};
	end
endmodule : bgl_panel_model

/* bench/test_bgl_display.sv */
// test_bgl_display: register-port scenarios for the bargraph display.
// assumes an 8-segment bar and a 4-cycle flash half period.
`timescale 1ns/10ps
module test_bgl_display import bgl_pkg::*; ;
	localparam int NSEG = 8;
	logic        mclk, nrst, reg_wr, reg_rd, over_range, under_range;
	logic [7:0]  reg_addr, seg_on;
	logic [31:0] reg_wdata, reg_rdata, digit_chars, rv;
	logic [15:0] seg_colour;
	logic [1:0]  dp;
	logic [8:0]  lit_count;
	logic        on_seen, off_seen;
	int          err_total, samples_checked;
	// mode table: control, reading, expected bar (origin at index 3)
	logic [7:0]  mctl[7] = '{8'h21, 8'h22, 8'h22, 8'h22, 8'h23, 8'h27, 8'h2b};
	logic [15:0] mval[7] = '{16'h0032, 16'h0014, 16'h0050, 16'h00c8,
		16'h0032, 16'h0032, 16'h0032};
	logic [7:0]  mexp[7] = '{8'hf0, 8'h0e, 8'h38, 8'hf8, 8'h08, 8'h1c, 8'h3e};

	bgl_display #(.NSEG(NSEG), .BLINK_HALF(4)) i_dut (
		.mclk                (mclk),
		.nrst                (nrst),
		.reg_addr            (reg_addr),
		.reg_wdata           (reg_wdata),
		.reg_wr              (reg_wr),
		.reg_rd              (reg_rd),
		.reg_rdata           (reg_rdata),
		.seg_on              (seg_on),
		.seg_colour          (seg_colour),
		.digit_chars         (digit_chars),
		.decimal_place_count (dp),
		.over_range          (over_range),
		.under_range         (under_range)
	);
	bgl_panel_model #(.NSEG(NSEG)) i_panel (
		.seg_on      (seg_on),
		.digit_chars (digit_chars),
		.lit_count   (lit_count)
	);

	// ----------------------------------------------------------------
	// bus and check tasks
	// ----------------------------------------------------------------
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e)
		begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask : wr
	// outputs settle one edge after the strobe is taken; decimal_place_count settles on that edge itself
	task automatic set(input logic [7:0] a, input logic [31:0] d);
		wr(a, d);
		repeat (2) @(posedge mclk);
		#1;
	endtask : set
	task automatic chkr(input logic [7:0] a, input logic [31:0] e);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask : chkr
	task automatic stop_test();
		$display("checks %0d errors %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : stop_test

	// ----------------------------------------------------------------
	// clock, watchdog, scenarios
	// ----------------------------------------------------------------
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end
	// the scenarios need a few hundred cycles; this is far beyond
	initial
	begin
		repeat (20000) @(posedge mclk);
		err_total++;
		stop_test();
	end
	initial
	begin
		{nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
		err_total = 0;
		samples_checked = 0;
		repeat (2) @(posedge mclk);
		nrst <= 1'b1;
		chkr(BGL_OFS_CTRL, 32'h30);
		chkr(8'hfc, 32'h0);
		chkr(BGL_OFS_FULL, 32'h64);
		set(BGL_OFS_CTRL, 32'h20);
		set(BGL_OFS_READING, 32'h0);
		chk(32'(seg_on), 32'h01);
		set(BGL_OFS_READING, 32'h32);
		chk(32'(seg_on), 32'h0f);
		chk(32'(lit_count), NSEG / 2);
		chk(digit_chars, 32'h30303530);
		set(BGL_OFS_READING, 32'h64);
		chk(32'(seg_on), 32'hff);
		chk(32'(seg_colour), 32'h6000);
		chkr(BGL_OFS_STATUS, 32'h03);
		set(BGL_OFS_READING, 32'hc8);
		chk(32'(seg_on), 32'hff);
		set(BGL_OFS_ORIGIN, 32'h32);
		set(BGL_OFS_READING, 32'h32);
		chk(32'(seg_on), 32'h0f);
		for (int i = 0; i < 7; i++)
		begin
			wr(BGL_OFS_CTRL, 32'(mctl[i]));
			set(BGL_OFS_READING, 32'(mval[i]));
			chk(32'(seg_on), 32'(mexp[i]));
		end
		set(BGL_OFS_CTRL, 32'h30);
		set(BGL_OFS_READING, 32'h1e);
		chk(32'(seg_on), 32'h67);
		wr(BGL_OFS_LIM0, 32'hc8);
		set(BGL_OFS_LIM0 + 8'h0c, 32'h0000ffce);
		chk(32'(seg_on), 32'ha7);
		set(BGL_OFS_CTRL, 32'h20);
		set(BGL_OFS_READING, 32'h64);
		chk(32'(seg_colour), 32'ha000);
		set(BGL_OFS_COLOUR, 32'h145);
		chk(32'(seg_colour), 32'h0555);
		chkr(BGL_OFS_COLOUR, 32'h145);
		set(BGL_OFS_READING, 32'h0000fffb);
		chk(digit_chars, 32'h2d303035);
		set(BGL_OFS_READING, 32'h2710);
		chk({over_range, under_range, seg_on}, 32'h2ff);
		chk(digit_chars, BGL_TXT_OVER);
		set(BGL_OFS_READING, 32'h0000fc18);
		chk({over_range, under_range, seg_on}, 32'h101);
		chk(digit_chars, BGL_TXT_UNDER);
		set(BGL_OFS_DECIMAL, 32'h2);
		chk(32'(dp), 32'h2);
		set(BGL_OFS_DECIMAL, 32'h3);
		chk(32'(dp), 32'h3);
		set(BGL_OFS_CTRL, 32'h00);
		chk(digit_chars, BGL_TXT_BLANK);
		set(BGL_OFS_TEXT, 32'h48454c50);
		chk(digit_chars, 32'h48454c50);
		chkr(BGL_OFS_TEXT, 32'h48454c50);
		set(BGL_OFS_CMD, 32'h4);
		chk(digit_chars, BGL_TXT_BLANK);
		set(BGL_OFS_CTRL, 32'h20);
		set(BGL_OFS_READING, 32'h64);
		wr(BGL_OFS_CMD, 32'h1);
		on_seen = 1'b0;
		off_seen = 1'b0;
		// two full flash periods must show both phases
		repeat (16)
		begin
			@(posedge mclk);
			#1;
			on_seen = on_seen | (seg_on === 8'hff);
			off_seen = off_seen | (seg_on === 8'h00);
		end
		chk(32'({on_seen, off_seen}), 32'h3);
		chkr(BGL_OFS_CTRL, 32'h60);
		set(BGL_OFS_CMD, 32'h2);
		on_seen = 1'b1;
		repeat (12)
		begin
			@(posedge mclk);
			#1;
			on_seen = on_seen & (seg_on === 8'hff);
		end
		chk(32'(on_seen), 32'h1);
		stop_test();
	end
endmodule : test_bgl_display

/* verilog/bgl_display.sv */
// bgl_display: bargraph and digit renderer for one panel meter channel.
// assumes a synchronous register port on mclk; segment and digit outputs
// drive the LED driver directly and are registered.
`timescale 1ns/10ps
module bgl_display
	import bgl_pkg::*;
#(
	parameter int NSEG        = 32,
	parameter int BLINK_HALF  = BGL_BLINK_CYC
)(
	// clock and reset
	input  wire logic                mclk,
	input  wire logic                nrst,
	// register port
	input  wire logic [7:0]          reg_addr,
	input  wire logic [31:0]         reg_wdata,
	input  wire logic                reg_wr,
	input  wire logic                reg_rd,
	output logic      [31:0]         reg_rdata,
	// bargraph segments
	output logic      [NSEG-1:0]     seg_on,
	output logic      [2*NSEG-1:0]   seg_colour,
	// digit display
	output logic      [31:0]         digit_chars,
	output logic      [1:0]          decimal_place_count,
	output logic                     over_range,
	output logic                     under_range
);
	localparam int IW = $clog2(NSEG);
	localparam int NSC = 6;  // reading, origin, four limits

	// ------------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------------
	if (NSEG < 5 || NSEG > 256)
		$error("bgl_display: NSEG must lie in 5..256");
	if (BLINK_HALF < 1)
		$error("bgl_display: BLINK_HALF must be at least 1");

	typedef struct packed {
		logic [1:0]        mode;
		logic [1:0]        ptr_sel;
		logic              mark_en;
		logic              disp_en;
		logic              blink_en;
		logic [15:0]       reading;
		logic [15:0]       full;
		logic [15:0]       zero;
		logic [15:0]       origin;
		logic [3:0][15:0]  lim;
		logic [9:0]        colour;
		logic [1:0]        dp;
		logic [31:0]       text;
		logic              text_valid;
		logic [31:0]       rdata;
		logic [31:0]       blink_cnt;
		logic              blink_ph;
		logic [NSEG-1:0]   seg_on;
		logic [2*NSEG-1:0] seg_col;
		logic [31:0]       chars;
		logic              over;
		logic              under;
	} bgl_state_s;

	bgl_state_s        st_q;
	bgl_state_s        st_d;
	logic [NSC-1:0][IW-1:0] idx;
	logic [NSC-1:0][15:0]   sval;
	logic [3:0]        alarm;

	// ------------------------------------------------------------------
	// scalers: one per value placed on the bar
	// ------------------------------------------------------------------
	// six parallel dividers cost area, but every index is ready in the
	// same cycle as the settings, with no sequencing to get wrong
	assign sval = {st_q.lim, st_q.origin, st_q.reading};

	for (genvar k = 0; k < NSC; k++)
	begin : g_scale
		bgl_scale_if #(.IW(IW)) sif ();
		assign sif.value = sval[k];
		assign sif.full  = st_q.full;
		assign sif.zero  = st_q.zero;
		assign idx[k]    = sif.index;
		bgl_scale #(.NSEG(NSEG), .IW(IW)) u_scale (.sc(sif.scaler));
	end

	// limit evaluation: lim[0..3] = upper two, upper one, lower one, lower two
	// strict compares: a reading sitting on a limit is not yet an alarm
	assign alarm[0] = $signed(st_q.reading) > $signed(st_q.lim[0]);
	assign alarm[1] = $signed(st_q.reading) > $signed(st_q.lim[1]);
	assign alarm[2] = $signed(st_q.reading) < $signed(st_q.lim[2]);
	assign alarm[3] = $signed(st_q.reading) < $signed(st_q.lim[3]);

	// ------------------------------------------------------------------
	// reading to four ascii characters, '-' leads negative values
	// ------------------------------------------------------------------
	function automatic logic [31:0] bgl_to_ascii(input logic [15:0] v);
		logic [13:0] mag;
		logic [15:0] bcd;
		logic        neg;
		logic [31:0] res;
		neg = v[15];
		mag = neg ? 14'(-$signed(v)) : v[13:0];
		bcd = '0;
		for (int b = 13; b >= 0; b--)
		begin
			for (int n = 0; n < 4; n++)
				if (bcd[n*4 +: 4] > 4'h4)
					bcd[n*4 +: 4] = bcd[n*4 +: 4] + 4'h3;
			bcd = {bcd[14:0], mag[b]};
		end
		for (int n = 0; n < 4; n++)
			res[n*8 +: 8] = {4'h3, bcd[n*4 +: 4]};
		if (neg)
			res[31:24] = 8'h2d;
		return res;
	endfunction : bgl_to_ascii

	// limit words sit on four word addresses just below the colour word;
	// write and read decode share this so they can never disagree
	function automatic logic bgl_is_lim(input logic [7:0] a);
		return a >= BGL_OFS_LIM0 && a < BGL_OFS_COLOUR && a[1:0] == 2'h0;
	endfunction : bgl_is_lim

	// ------------------------------------------------------------------
	// next state: register writes, blink timer, segment and digit images
	// ------------------------------------------------------------------
	always_comb
	begin
		int          d;
		int          half;
		logic [IW-1:0] lo;
		logic [IW-1:0] hi;
		logic        lit;
		logic [1:0]  col;
		logic        flash_off;
		d = 0;
		half = 0;
		lo = '0;
		hi = '0;
		lit = 1'b0;
		col = BGL_COL_GREEN;
		flash_off = 1'b0;
		st_d = st_q;

		// register writes are accepted in the strobe cycle
		if (reg_wr)
		begin
			if (reg_addr == BGL_OFS_CTRL)
			begin
				st_d.mode    = reg_wdata[BGL_CTRL_MODE_LSB +: 2];
				st_d.ptr_sel = reg_wdata[BGL_CTRL_PTR_LSB +: 2];
				st_d.mark_en = reg_wdata[BGL_CTRL_MARK];
				st_d.disp_en = reg_wdata[BGL_CTRL_DISP];
			end
			else if (reg_addr == BGL_OFS_CMD)
			begin
				if (reg_wdata[BGL_CMD_BLINK_ON])
					st_d.blink_en = 1'b1;
				if (reg_wdata[BGL_CMD_BLINK_OFF])
					st_d.blink_en = 1'b0;
				if (reg_wdata[BGL_CMD_TEXT_CLR])
					st_d.text_valid = 1'b0;
			end
			else if (reg_addr == BGL_OFS_READING)
				st_d.reading = reg_wdata[15:0];
			else if (reg_addr == BGL_OFS_FULL)
				st_d.full = reg_wdata[15:0];
			else if (reg_addr == BGL_OFS_ZERO)
				st_d.zero = reg_wdata[15:0];
			else if (reg_addr == BGL_OFS_ORIGIN)
				st_d.origin = reg_wdata[15:0];
			else if (bgl_is_lim(reg_addr))
				st_d.lim[2'(reg_addr[7:2] - BGL_OFS_LIM0[7:2])] =
					reg_wdata[15:0];
			else if (reg_addr == BGL_OFS_COLOUR)
				st_d.colour = reg_wdata[9:0];
			else if (reg_addr == BGL_OFS_DECIMAL)
				st_d.dp = reg_wdata[1:0];
			else if (reg_addr == BGL_OFS_TEXT)
			begin
				st_d.text = reg_wdata;
				st_d.text_valid = 1'b1;
			end
		end

		// read data stands only in the cycle after the strobe
		st_d.rdata = '0;
		if (reg_rd)
		begin
			if (reg_addr == BGL_OFS_CTRL)
				st_d.rdata = {25'h0, st_q.blink_en, st_q.disp_en,
					st_q.mark_en, st_q.ptr_sel, st_q.mode};
			else if (reg_addr == BGL_OFS_READING)
				st_d.rdata = {16'h0, st_q.reading};
			else if (reg_addr == BGL_OFS_FULL)
				st_d.rdata = {16'h0, st_q.full};
			else if (reg_addr == BGL_OFS_ZERO)
				st_d.rdata = {16'h0, st_q.zero};
			else if (reg_addr == BGL_OFS_ORIGIN)
				st_d.rdata = {16'h0, st_q.origin};
			else if (bgl_is_lim(reg_addr))
				st_d.rdata = {16'h0,
					st_q.lim[2'(reg_addr[7:2] - BGL_OFS_LIM0[7:2])]};
			else if (reg_addr == BGL_OFS_COLOUR)
				st_d.rdata = {22'h0, st_q.colour};
			else if (reg_addr == BGL_OFS_DECIMAL)
				st_d.rdata = {30'h0, st_q.dp};
			else if (reg_addr == BGL_OFS_TEXT)
				st_d.rdata = st_q.text;
			else if (reg_addr == BGL_OFS_STATUS)
				st_d.rdata = {25'h0, st_q.text_valid, st_q.under,
					st_q.over, alarm};
		end

		// free-running flash timer; half period in cycles
		// never restarted: the first dark phase after an alarm may be short
		if (st_q.blink_cnt >= 32'(BLINK_HALF - 1))
		begin
			st_d.blink_cnt = '0;
			st_d.blink_ph  = ~st_q.blink_ph;
		end
		else
			st_d.blink_cnt = st_q.blink_cnt + 32'h1;
		flash_off = st_q.blink_en && (|alarm) && st_q.blink_ph;

		// pointer half width: 0, 1 or 2 segments either side
		half = (st_q.ptr_sel == 2'h0) ? 0 : (st_q.ptr_sel == 2'h1) ? 1 : 2;
		// origin only enters the bi-directional span
		lo = (idx[1] < idx[0]) ? idx[1] : idx[0];
		hi = (idx[1] < idx[0]) ? idx[0] : idx[1];

		// segment image, recomputed from the settings every cycle
		for (int i = 0; i < NSEG; i++)
		begin
			d = i - int'(idx[0]);
			case (st_q.mode)
				BGL_MODE_BOT: lit = IW'(i) <= idx[0];
				BGL_MODE_TOP:
					lit = IW'(NSEG - 1 - i) <= idx[0];
				BGL_MODE_BI:
					lit = IW'(i) >= lo && IW'(i) <= hi;
				default: lit = d <= half && d >= -half;
			endcase
			// colouring by zone beyond each exceeded limit
			col = st_q.colour[1:0];
			if (alarm[0] && IW'(i) > idx[2])
				col = st_q.colour[3:2];
			else if (alarm[1] && IW'(i) > idx[3])
				col = st_q.colour[5:4];
			if (alarm[3] && IW'(i) < idx[5])
				col = st_q.colour[9:8];
			else if (alarm[2] && IW'(i) < idx[4])
				col = st_q.colour[7:6];
			// limit marks, clamped ends come from the scaler
			if (st_q.mark_en)
			begin
				for (int k = 0; k < 4; k++)
					if (IW'(i) == idx[k+2])
					begin
						lit = 1'b1;
						col = st_q.colour[2*k+2 +: 2];
					end
			end
			st_d.seg_on[i] = lit && !flash_off;
			st_d.seg_col[2*i +: 2] = col;
		end

		// digits: text wins, then blank, then range words, then value
		st_d.over  = $signed(st_q.reading) > 16'(BGL_DIG_MAX);
		st_d.under = $signed(st_q.reading) < $signed(16'(BGL_DIG_MIN));
		if (st_q.text_valid)
			st_d.chars = st_q.text;
		else if (!st_q.disp_en)
			st_d.chars = BGL_TXT_BLANK;
		else if (st_d.over)
			st_d.chars = BGL_TXT_OVER;
		else if (st_d.under)
			st_d.chars = BGL_TXT_UNDER;
		else
			st_d.chars = bgl_to_ascii(st_q.reading);
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------
	// settings reset to their defaults; the images follow one edge later
	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_q            <= '0;
			st_q.mode       <= BGL_RST_CTRL[1:0];
			st_q.ptr_sel    <= BGL_RST_CTRL[3:2];
			st_q.mark_en    <= BGL_RST_CTRL[BGL_CTRL_MARK];
			st_q.disp_en    <= BGL_RST_CTRL[BGL_CTRL_DISP];
			st_q.full       <= BGL_RST_FULL;
			st_q.zero       <= BGL_RST_ZERO;
			st_q.lim        <= {BGL_RST_LO2, BGL_RST_LO1,
				BGL_RST_UP1, BGL_RST_UP2};
			st_q.colour     <= BGL_RST_COLOUR;
			st_q.chars      <= BGL_TXT_BLANK;
		end
		else
			st_q <= st_d;
	end

	// outputs straight from flip-flops
	assign reg_rdata           = st_q.rdata;
	assign seg_on              = st_q.seg_on;
	assign seg_colour          = st_q.seg_col;
	assign digit_chars         = st_q.chars;
	assign decimal_place_count = st_q.dp;
	assign over_range          = st_q.over;
	assign under_range         = st_q.under;
endmodule : bgl_display

/* verilog/bgl_pkg.sv */
// bgl_pkg: register map, field layout, reset values and timing constants
// for the bargraph limit display.
// assumes a 32-bit register port and signed 16-bit readings and settings.
package bgl_pkg;

	// ------------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] BGL_OFS_CTRL    = 8'h00;
	localparam logic [7:0] BGL_OFS_CMD     = 8'h04;
	localparam logic [7:0] BGL_OFS_READING = 8'h08;
	localparam logic [7:0] BGL_OFS_FULL    = 8'h0c;
	localparam logic [7:0] BGL_OFS_ZERO    = 8'h10;
	localparam logic [7:0] BGL_OFS_ORIGIN  = 8'h14;
	localparam logic [7:0] BGL_OFS_LIM0    = 8'h18;  // upper two, upper one,
	localparam logic [7:0] BGL_OFS_COLOUR  = 8'h28;  // lower one, lower two
	localparam logic [7:0] BGL_OFS_DECIMAL = 8'h2c;
	localparam logic [7:0] BGL_OFS_TEXT    = 8'h30;
	localparam logic [7:0] BGL_OFS_STATUS  = 8'h34;

	// ------------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------------
	localparam int BGL_CTRL_MODE_LSB = 0;  // bar_direction_select, 2 bits
	localparam int BGL_CTRL_PTR_LSB  = 2;  // pointer width select, 2 bits
	localparam int BGL_CTRL_MARK     = 4;  // limit_mark_enable
	localparam int BGL_CTRL_DISP     = 5;  // reading display enable
	localparam int BGL_CTRL_BLINK    = 6;  // blink enable, read only here
	localparam int BGL_CMD_BLINK_ON  = 0;  // limit_blink_on_cmd
	localparam int BGL_CMD_BLINK_OFF = 1;  // limit_blink_off_cmd
	localparam int BGL_CMD_TEXT_CLR  = 2;  // drop digit_text_override

	// ------------------------------------------------------------------
	// modes and colours
	// ------------------------------------------------------------------
	localparam logic [1:0] BGL_MODE_BOT = 2'h0;
	localparam logic [1:0] BGL_MODE_TOP = 2'h1;
	localparam logic [1:0] BGL_MODE_BI  = 2'h2;
	localparam logic [1:0] BGL_MODE_PTR = 2'h3;
	localparam logic [1:0] BGL_COL_GREEN = 2'h0;
	localparam logic [1:0] BGL_COL_RED   = 2'h1;
	localparam logic [1:0] BGL_COL_AMBER = 2'h2;

	// ------------------------------------------------------------------
	// reset values: bar spans 0..100 with limits at 90/80/20/10
	// ------------------------------------------------------------------
	localparam logic [15:0] BGL_RST_FULL = 16'h0064;
	localparam logic [15:0] BGL_RST_ZERO = 16'h0000;
	localparam logic [15:0] BGL_RST_UP2  = 16'h005a;
	localparam logic [15:0] BGL_RST_UP1  = 16'h0050;
	localparam logic [15:0] BGL_RST_LO1  = 16'h0014;
	localparam logic [15:0] BGL_RST_LO2  = 16'h000a;
	localparam logic [9:0]  BGL_RST_COLOUR = {BGL_COL_RED, BGL_COL_AMBER,
		BGL_COL_AMBER, BGL_COL_RED, BGL_COL_GREEN};
	localparam logic [5:0]  BGL_RST_CTRL = 6'h30;  // bottom-up, marks, digits

	// ------------------------------------------------------------------
	// digit words and timing
	// ------------------------------------------------------------------
	localparam logic [31:0] BGL_TXT_BLANK = 32'h20202020;
	localparam logic [31:0] BGL_TXT_OVER  = 32'h206f7672;  // " ovr"
	localparam logic [31:0] BGL_TXT_UNDER = 32'h20556e64;  // " Und"
	localparam int          BGL_DIG_MAX   = 9999;
	localparam int          BGL_DIG_MIN   = -999;
	localparam int          BGL_CLK_MHZ   = 200;
	localparam int          BGL_BLINK_MS  = 250;  // half period of the flash
	localparam int          BGL_BLINK_CYC = BGL_BLINK_MS * 1000 * BGL_CLK_MHZ;

endpackage : bgl_pkg

/* verilog/bgl_scale.sv */
// bgl_scale: maps a signed value onto a segment index between zero and
// full scale, clamped to the first and last segment.
// assumes signed 16-bit operands; purely combinational.
`timescale 1ns/10ps
module bgl_scale
	import bgl_pkg::*;
#(
	parameter int NSEG = 32,
	parameter int IW   = 5
)(
	// value in, index out
	bgl_scale_if.scaler sc
);
	// the index must be wide enough to name the last segment
	if (NSEG < 2 || IW < $clog2(NSEG))
		$error("bgl_scale: IW too narrow for NSEG");

	logic signed [16:0] diff;
	logic signed [16:0] span;
	logic [16+IW:0]     prod;
	logic [16+IW:0]     quot;

	// proportional position; a reversed span pins the bar at the bottom
	always_comb
	begin
		diff = 17'($signed(sc.value)) - 17'($signed(sc.zero));
		span = 17'($signed(sc.full)) - 17'($signed(sc.zero));
		prod = (17+IW)'(unsigned'(diff)) * (17+IW)'(NSEG - 1);
		quot = prod / (17+IW)'(unsigned'(span));
		if (span <= 17'sh0 || diff <= 17'sh0)
			sc.index = '0;
		else if (diff >= span)
			sc.index = IW'(NSEG - 1);
		else
			sc.index = IW'(quot);
	end
endmodule : bgl_scale

/* verilog/bgl_scale_if.sv */
// bgl_scale_if: carries one value and the bar span to a scaler and the
// clamped segment index back.
// assumes both ends run on the same clock; the path is combinational.
`timescale 1ns/10ps
interface bgl_scale_if #(
	parameter int IW = 5
);
	logic [15:0]   value;
	logic [15:0]   full;
	logic [15:0]   zero;
	logic [IW-1:0] index;

	modport client (output value, output full, output zero, input index);
	modport scaler (input value, input full, input zero, output index);
endinterface : bgl_scale_if
